/* shared/pdt_pkg.sv */
// Purpose: Constants for the positioning dwell timer
// Assumes: 40 MHz system clock, dwell counted in whole milliseconds
// Notes:   Table patterns and timing shared by the timer and its tick source
// How it works
// - End-point table: dwell, then raise done
// - Continuous chain: skip intermediate dwell entirely
// - Stop-between chain: dwell before next table
// - Final chain table dwells like end-point
package pdt_pkg;
    localparam int          CLK_HZ       = 40000000;
    localparam int          MS_PER_S     = 1000;
    localparam int          TICK_CYCLES  = CLK_HZ / MS_PER_S;
    localparam int          DWELL_W      = 15;
    localparam logic [14:0] DWELL_MAX    = 15'h7FFF;
    localparam int          TICK_W       = 16;

    // Pattern of the table that just finished
    typedef enum logic [1:0] {
        PDT_PAT_END   = 2'b00,
        PDT_PAT_CONT  = 2'b01,
        PDT_PAT_STOP  = 2'b10
    } pdt_pat_type;

    typedef enum logic [1:0] {
        PDT_IDLE  = 2'b00,
        PDT_MOVE  = 2'b01,
        PDT_DWELL = 2'b10
    } pdt_state_type;
endpackage

/* hdl/pdt_ms_tick.sv */
// Purpose: Millisecond tick generator
// Assumes: Synchronous clear restarts a fresh full millisecond
// Notes:   Clearing at dwell start keeps the dwell from being short
`timescale 1ns/10ps
module pdt_ms_tick #(
    parameter int TICKS = pdt_pkg::TICK_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    input  wire logic i_clr,
    output logic      o_tick
);
    logic [pdt_pkg::TICK_W-1:0] cnt_q;
    logic [pdt_pkg::TICK_W-1:0] cnt_d;
    localparam logic [pdt_pkg::TICK_W-1:0] LAST = pdt_pkg::TICK_W'(TICKS - 1);

    // Wrap counter over one millisecond
    always_comb begin
        cnt_d = cnt_q;
        if (i_clr) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
        end
    end

    // Tick on the last cycle of each millisecond; a registered pulse
    // would stretch every dwell by one cycle
    assign o_tick = (cnt_q == LAST) & ~i_clr;
endmodule

/* hdl/pdt_dwell_timer.sv */
// Purpose: Dwell timer between positioning tables in automatic operation
// Assumes: Motion core reports each table's completion with its pattern and dwell
// Notes:   Start pulses are ignored while busy; continuous tables pass straight on
`timescale 1ns/10ps
module pdt_dwell_timer #(
    parameter int TICKS = pdt_pkg::TICK_CYCLES
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_ce,
    input  wire logic                        i_start,
    input  wire logic                        i_tbl_done,
    input  wire pdt_pkg::pdt_pat_type        i_tbl_pat,
    input  wire logic [pdt_pkg::DWELL_W-1:0] i_tbl_dwell_ms,
    output logic                             o_busy,
    output logic                             o_op_done,
    output logic                             o_next_tbl,
    output logic                             o_dwell_active
);
    pdt_pkg::pdt_state_type     state_q, state_d;
    logic [pdt_pkg::DWELL_W-1:0] rem_q, rem_d;
    logic                        final_q, final_d;
    logic                        busy_q, busy_d;
    logic                        done_q, done_d;
    logic                        next_q, next_d;
    logic                        dwell_q, dwell_d;
    logic                        tick;
    logic                        tick_clr;

    // Restart the millisecond grid whenever a dwell begins
    assign tick_clr = (state_q == pdt_pkg::PDT_MOVE) && i_tbl_done;

    pdt_ms_tick #(.TICKS(TICKS)) u_tick (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_clr   (tick_clr),
        .o_tick  (tick)
    );

    // Sequencer: move, dwell, then next table or done
    always_comb begin
        state_d = state_q;
        rem_d   = rem_q;
        final_d = final_q;
        busy_d  = busy_q;
        done_d  = done_q;
        next_d  = 1'b0;
        case (state_q)
            pdt_pkg::PDT_IDLE: begin
                if (i_start) begin
                    state_d = pdt_pkg::PDT_MOVE;
                    busy_d  = 1'b1;
                    done_d  = 1'b0;
                end
            end
            pdt_pkg::PDT_MOVE: begin
                if (i_tbl_done) begin
                    if (i_tbl_pat == pdt_pkg::PDT_PAT_CONT) begin
                        next_d = 1'b1;
                    end else begin
                        // Zero dwell still spends one cycle here; keeps timing uniform
                        state_d = pdt_pkg::PDT_DWELL;
                        rem_d   = i_tbl_dwell_ms;
                        final_d = (i_tbl_pat == pdt_pkg::PDT_PAT_END);
                    end
                end
            end
            pdt_pkg::PDT_DWELL: begin
                if (rem_q == '0) begin
                    if (final_q) begin
                        state_d = pdt_pkg::PDT_IDLE;
                        busy_d  = 1'b0;
                        done_d  = 1'b1;
                    end else begin
                        state_d = pdt_pkg::PDT_MOVE;
                        next_d  = 1'b1;
                    end
                end else if (tick) begin
                    rem_d = rem_q - 1'b1;
                end
            end
            default: begin
                state_d = pdt_pkg::PDT_IDLE;
                busy_d  = 1'b0;
            end
        endcase
        // Registered flag so the pin never shows a raw state decode
        dwell_d = (state_d == pdt_pkg::PDT_DWELL);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= pdt_pkg::PDT_IDLE;
            rem_q   <= '0;
            final_q <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            next_q  <= 1'b0;
            dwell_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            rem_q   <= rem_d;
            final_q <= final_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            next_q  <= next_d;
            dwell_q <= dwell_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_busy         = busy_q;
    assign o_op_done      = done_q;
    assign o_next_tbl     = next_q;
    assign o_dwell_active = dwell_q;

    // Busy and done are never both high
    property p_busy_done_excl;
        @(posedge i_clk) disable iff (!i_rst_b) !(busy_q && done_q);
    endproperty
    a_busy_done_excl: assert property (p_busy_done_excl)
        else $error("busy and done high together");

    // Zero-dwell end table: done two cycles after completion
    sequence s_end_zero;
        (state_q == pdt_pkg::PDT_MOVE) && i_tbl_done && i_ce
            && (i_tbl_pat == pdt_pkg::PDT_PAT_END) && (i_tbl_dwell_ms == '0);
    endsequence
    property p_end_zero;
        @(posedge i_clk) disable iff (!i_rst_b) s_end_zero ##1 i_ce |=> done_q && !busy_q;
    endproperty
    a_end_zero: assert property (p_end_zero)
        else $error("end table did not finish after zero dwell");

    // Continuous table passes on next cycle with no dwell
    property p_cont;
        @(posedge i_clk) disable iff (!i_rst_b)
            (state_q == pdt_pkg::PDT_MOVE) && i_tbl_done && i_ce
            && (i_tbl_pat == pdt_pkg::PDT_PAT_CONT)
            |=> next_q && (state_q == pdt_pkg::PDT_MOVE);
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous table was delayed");

    // Nonzero dwell blocks next table and done for a while
    property p_dwell_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
            (state_q == pdt_pkg::PDT_MOVE) && i_tbl_done && i_ce
            && (i_tbl_pat != pdt_pkg::PDT_PAT_CONT) && (i_tbl_dwell_ms != '0)
            |=> (!next_q && !done_q && busy_q)[*2];
    endproperty
    a_dwell_hold: assert property (p_dwell_hold)
        else $error("dwell cut short");

    // Done only ever follows a final dwell
    property p_done_cause;
        @(posedge i_clk) disable iff (!i_rst_b)
            $rose(done_q) |-> $past(state_q) == pdt_pkg::PDT_DWELL && $past(final_q);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done raised without final dwell");

    // Remaining count only drops by one on a tick
    property p_count;
        @(posedge i_clk) disable iff (!i_rst_b)
            (state_q == pdt_pkg::PDT_DWELL) && (rem_q != '0) && i_ce
            |=> rem_q == $past(rem_q) - (($past(tick)) ? 15'h0001 : 15'h0000);
    endproperty
    a_count: assert property (p_count)
        else $error("dwell count step wrong");

    // Busy stays high while dwelling
    property p_busy_dwell;
        @(posedge i_clk) disable iff (!i_rst_b) (state_q != pdt_pkg::PDT_IDLE) |-> busy_q;
    endproperty
    a_busy_dwell: assert property (p_busy_dwell)
        else $error("busy dropped during operation");

    // Clock enable low freezes outputs
    property p_freeze;
        @(posedge i_clk) disable iff (!i_rst_b)
            !i_ce |=> $stable(busy_q) && $stable(done_q) && !($changed(state_q));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    // Dwell only ever starts from a completion that is not continuous
    property p_dwell_start;
        @(posedge i_clk) disable iff (!i_rst_b)
            $rose(dwell_q) |-> $past(i_tbl_done) && ($past(state_q) == pdt_pkg::PDT_MOVE)
            && ($past(i_tbl_pat) != pdt_pkg::PDT_PAT_CONT);
    endproperty
    a_dwell_start: assert property (p_dwell_start)
        else $error("dwell began without a finished table");

    // Next-table request is a single-cycle pulse
    property p_next_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
            next_q && i_ce && !i_tbl_done |=> !next_q;
    endproperty
    a_next_pulse: assert property (p_next_pulse)
        else $error("next-table pulse stretched");

    // Zero-dwell stop table: next table two cycles after completion
    sequence s_stop_zero;
        (state_q == pdt_pkg::PDT_MOVE) && i_tbl_done && i_ce
            && (i_tbl_pat == pdt_pkg::PDT_PAT_STOP) && (i_tbl_dwell_ms == '0);
    endsequence
    property p_stop_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
            s_stop_zero ##1 i_ce |=> next_q && busy_q && (state_q == pdt_pkg::PDT_MOVE);
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("stop table did not pass on after zero dwell");

    // Start from idle raises busy and clears done
    property p_start_busy;
        @(posedge i_clk) disable iff (!i_rst_b)
            (state_q == pdt_pkg::PDT_IDLE) && i_start && i_ce |=> busy_q && !done_q;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not raise busy");

    // Done stands until the next start
    property p_done_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
            done_q && !i_start |=> done_q;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped without a start");
endmodule

/* sim/pdt_host_model.sv */
// Purpose: Controlling program model that starts automatic operation
// Assumes: Start is a one-cycle pulse, only issued while the timer is idle
// Notes:   Drives on the falling edge so the timer samples settled values
`timescale 1ns/10ps
module pdt_host_model (
    input  wire logic i_clk,
    input  wire logic i_go,
    input  wire logic i_busy,
    output logic      o_start
);
    initial o_start = 1'b0;

    // One pulse per request; never re-issued while busy
    always @(negedge i_clk) begin
        o_start <= i_go & ~i_busy & ~o_start;
    end
endmodule

/* sim/testbench.sv */
// Purpose: Self-checking bench for the dwell timer
// Assumes: Short millisecond (TICKS=4) so long dwells stay cheap
// Notes:   Random chains of tables, each ending with a final table
`timescale 1ns/10ps
module testbench;
    localparam int TICKS = 4;
    logic                 clk          = 1'b0;
    logic                 rst_b        = 1'b0;
    logic                 ce           = 1'b1;
    logic                 go           = 1'b0;
    logic                 tbl_done     = 1'b0;
    pdt_pkg::pdt_pat_type pat          = pdt_pkg::PDT_PAT_END;
    logic [14:0]          dwell        = 15'h0000;
    logic                 start;
    logic                 busy;
    logic                 op_done;
    logic                 next_tbl;
    logic                 dwell_act;
    int                   fail_count   = 0;
    int                   total_checks = 0;
    int                   cycles       = 0;
    int                   n;

    always #12.5 clk = ~clk;

    pdt_dwell_timer #(.TICKS(TICKS)) pdt_dwell_timer_inst (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_start(start),
        .i_tbl_done(tbl_done), .i_tbl_pat(pat), .i_tbl_dwell_ms(dwell),
        .o_busy(busy), .o_op_done(op_done), .o_next_tbl(next_tbl),
        .o_dwell_active(dwell_act));

    pdt_host_model pdt_host_model_inst (
        .i_clk(clk), .i_go(go), .i_busy(busy), .o_start(start));

    // Sample at which the result shows; continuous skips dwell, freeze adds
    function automatic int lat(pdt_pkg::pdt_pat_type p, logic [14:0] ms, int fz);
        return (p == pdt_pkg::PDT_PAT_CONT) ? 1 : int'(ms) * TICKS + 2 + fz;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Request a start through the host and wait for busy
    task automatic begin_op();
        int w;
        w = 0;
        @(negedge clk);
        go = 1'b1;
        while (busy !== 1'b1 && w < 10) begin
            @(negedge clk);
            w++;
        end
        go = 1'b0;
        chk(busy, 1'b1);
        chk(op_done, 1'b0);
    endtask

    // Report one table completion, then time the outcome
    task automatic run_tbl(input pdt_pkg::pdt_pat_type p, input logic [14:0] ms, input int fz);
        int   cnt;
        logic bad;
        logic dw_bad;
        @(negedge clk);
        tbl_done = 1'b1;
        pat = p;
        dwell = ms;
        @(negedge clk);
        tbl_done = 1'b0;
        dwell = 15'($urandom);
        cnt = 1;
        bad = 1'b0;
        dw_bad = 1'b0;
        // Busy and dwell flag hold all through the dwell; first fz edges frozen
        while (!(op_done === 1'b1 || next_tbl === 1'b1) && cnt < 400) begin
            ce = (cnt > fz);
            bad |= (busy !== 1'b1);
            dw_bad |= (dwell_act !== 1'b1);
            @(negedge clk);
            cnt++;
        end
        ce = 1'b1;
        chk(bad, 1'b0);
        chk(dw_bad, 1'b0);
        chk(cnt, lat(p, ms, fz));
        chk(dwell_act, 1'b0);
        chk(op_done, p == pdt_pkg::PDT_PAT_END);
        chk(next_tbl, p != pdt_pkg::PDT_PAT_END);
        chk(busy, p != pdt_pkg::PDT_PAT_END);
    endtask

    // Hang guard; tests need well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(11));
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        // Corners: huge ignored dwell, zero dwells
        begin_op();
        run_tbl(pdt_pkg::PDT_PAT_CONT, 15'h7FFF, 0);
        run_tbl(pdt_pkg::PDT_PAT_STOP, 15'h0000, 0);
        run_tbl(pdt_pkg::pdt_pat_type'(2'h3), 15'h0002, 3);
        run_tbl(pdt_pkg::PDT_PAT_END, 15'h0000, 0);
        $display("test corner done");
        // Random chains ending in a final table
        for (int k = 0; k < 12; k++) begin
            begin_op();
            n = $urandom_range(0, 3);
            repeat (n) begin
                run_tbl($urandom_range(0, 1) ? pdt_pkg::PDT_PAT_CONT : pdt_pkg::PDT_PAT_STOP,
                        15'($urandom_range(0, 6)), $urandom_range(0, 2));
            end
            run_tbl(pdt_pkg::PDT_PAT_END, 15'($urandom_range(0, 6)), $urandom_range(0, 2));
            $display("test chain %0d done", k);
        end
        print_verdict();
    end
endmodule
